/* logic/hbc_regs.svh */
/*
 * holds the offsets, field positions, reset values and timing counts of the
 * host bridge identification and command registers.
 * assumes it is included by its bare name from the package and the modules.
 */
`ifndef HBC_REGS_SVH
`define HBC_REGS_SVH

// dword-aligned configuration offsets
`define HBC_OFF_IDENT 8'h00
`define HBC_OFF_CMDSTS 8'h04

// command word fields
`define HBC_CMD_SYSTEM_ERROR_ENABLE_BIT 8
`define HBC_CMD_PARITY_ERROR_ENABLE_BIT 6
`define HBC_CMD_RESET 16'h0006
`define HBC_CMD_FIXED 16'h0006
`define HBC_CMD_SYSTEM_ERROR_ENABLE_RESET 1'h0
`define HBC_CMD_PARITY_ERROR_ENABLE_RESET 1'h0

// status word fields
`define HBC_STS_DPE_BIT 15
`define HBC_STS_SSE_BIT 14
`define HBC_STS_RTAS_BIT 12
`define HBC_STS_FIXED 16'h0200

// perr pin: cycles driven low, then one cycle driven high before release
`define HBC_PERR_LOW_CYCLES 2'h1

`endif

/* logic/hbc_pkg.sv */
/*
 * holds the types shared by the host bridge command register modules.
 * assumes hbc_regs.svh sits on the include path.
 */
package hbc_pkg;
    `include "hbc_regs.svh"

    // configuration word as seen on the register port
    typedef logic [15:0] hbc_half_t;

    // perr pin driver states
    typedef enum logic [1:0] {
        HBC_PERR_IDLE = 2'b00,
        HBC_PERR_LOW  = 2'b01,
        HBC_PERR_HIGH = 2'b10
    } hbc_perr_st_t;
endpackage

/* logic/hbc_err_if.sv */
/*
 * holds the interface between the command register core and the error gate.
 * assumes both ends run on ref_clk; every signal is a level or a one-cycle pulse.
 */
`timescale 1ns/1ns
interface hbc_err_if;
    logic system_error_enable;         // system error enable from the command word
    logic parity_error_enable;         // parity error enable from the command word
    logic perr_serr_en;  // error command enable for sampled perr
    logic ev_tabort;     // own transaction ended by target abort
    logic ev_apar;       // address phase parity error
    logic ev_dpar;       // data phase parity error while receiving
    logic ev_perr_smp;   // perr sampled asserted on the bus
    logic serr_req;      // pulse: drive serr now
    logic perr_req;      // pulse: drive perr now
    logic dpe_set;       // pulse: set detected parity flag

    modport core (output system_error_enable, parity_error_enable, perr_serr_en, ev_tabort, ev_apar, ev_dpar, ev_perr_smp,
                  input serr_req, perr_req, dpe_set);
    modport gate (input system_error_enable, parity_error_enable, perr_serr_en, ev_tabort, ev_apar, ev_dpar, ev_perr_smp,
                  output serr_req, perr_req, dpe_set);
endinterface

/* logic/hbc_err_gate.sv */
/*
 * holds the combinational gating of bus error events by the command enables.
 * assumes events are one-cycle pulses from the bus interface logic.
 */
`timescale 1ns/1ns
module hbc_err_gate (
    hbc_err_if.gate err
);
    import hbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // parity errors only reach serr and perr when parity reporting is on
    logic apar_rep;  // address parity routed to serr
    logic perr_rep;  // sampled perr routed to serr

    always_comb begin
        apar_rep = err.ev_apar & err.parity_error_enable & err.system_error_enable;
        perr_rep = err.ev_perr_smp & err.perr_serr_en & err.parity_error_enable & err.system_error_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // serr: target abort, address parity, sampled perr; never without system_error_enable
    always_comb begin
        err.serr_req = (err.ev_tabort & err.system_error_enable) | apar_rep | perr_rep;
    end

    // perr carries data phase errors only, address parity never goes there
    always_comb begin
        err.perr_req = err.ev_dpar & err.parity_error_enable;
    end

    // detection flag ignores the enables entirely
    always_comb begin
        err.dpe_set = err.ev_apar | err.ev_dpar;
    end
endmodule

/* logic/hbc_cfg_top.sv */
/*
 * holds the identification, command and minimal status words of the host
 * bridge configuration header, plus the serr and perr pin drivers.
 * assumes a configuration cycle decoder in front that presents one dword
 * access per cfg_req pulse, and bus logic that reports errors as pulses.
 */
// Notes on behaviour
// - maker code at offset zero, read only
// - part code at offset two, read only
// - command resets to 0006h, two enables defined
// - system_error_enable set lets errors assert serr
// - system_error_enable clear means serr never driven
// - target abort on own cycle asserts serr
// - address parity to serr needs both enables
// - sampled perr to serr via error command
// - system_error_enable covers primary bus errors only
// - parity_error_enable reports received data parity on perr
// - address parity goes serr, never perr
// - parity_error_enable clear hides all parity reports
// - detected parity flag sets regardless of parity_error_enable
`timescale 1ns/1ns
`include "hbc_regs.svh"
module hbc_cfg_top #(
    parameter logic [15:0] MAKER_CODE = 16'h1A2B, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h3C4D   // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic perr_serr_en,
    input wire logic ev_tabort,
    input wire logic ev_apar,
    input wire logic ev_dpar,
    input wire logic ev_perr_smp,
    output logic serr_n_o,
    output logic serr_oe_n,
    output logic perr_n_o,
    output logic perr_oe_n,
    output logic cmd_system_error_enable,
    output logic cmd_parity_error_enable
);
    import hbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    hbc_err_if err_bus ();  // carrier to the error gate

    logic system_error_enable_ff;         // system error enable
    logic nxt_system_error_enable;
    logic parity_error_enable_ff;         // parity error enable
    logic nxt_parity_error_enable;
    logic dpe_ff;           // detected parity error flag
    logic nxt_dpe;
    logic sse_ff;           // signalled system error flag
    logic nxt_sse;
    logic rtas_ff;          // received target abort flag
    logic nxt_rtas;
    logic [31:0] rdata_ff;  // registered read data
    logic [31:0] nxt_rdata;
    logic ack_ff;           // one-cycle access answer
    logic nxt_ack;
    logic serr_act_ff;      // serr driven this cycle
    logic nxt_serr_act;
    hbc_perr_st_t perr_st_ff;  // perr pin state
    hbc_perr_st_t nxt_perr_st;
    logic [1:0] perr_cnt_ff;   // cycles left low
    logic [1:0] nxt_perr_cnt;

    logic sel_ident;        // access hits the identification dword
    logic sel_cmdsts;       // access hits the command and status dword
    logic wr_cmdsts;        // write strobe for that dword
    hbc_half_t cmd_rd;      // command word as read
    hbc_half_t sts_rd;      // status word as read

    // offsets as named constants so their dword part can be sliced
    localparam logic [7:0] OFF_IDENT = `HBC_OFF_IDENT;
    localparam logic [7:0] OFF_CMDSTS = `HBC_OFF_CMDSTS;

    ////////////////////////////////////////////////////////////////////////////
    // address decode, low two address bits ignored since access is by dword

    always_comb begin
        sel_ident = cfg_req & (cfg_addr[7:2] == OFF_IDENT[7:2]);
        sel_cmdsts = cfg_req & (cfg_addr[7:2] == OFF_CMDSTS[7:2]);
        wr_cmdsts = sel_cmdsts & cfg_we;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read views of the words

    // bits 2:1 keep the reset pattern as fixed ones so the word reads 0006h
    // after reset; every other reserved bit is a constant zero
    always_comb begin
        cmd_rd = `HBC_CMD_FIXED;
        cmd_rd[`HBC_CMD_SYSTEM_ERROR_ENABLE_BIT] = system_error_enable_ff;
        cmd_rd[`HBC_CMD_PARITY_ERROR_ENABLE_BIT] = parity_error_enable_ff;
    end

    // only the flags this block owns; the rest of status lives elsewhere
    always_comb begin
        sts_rd = `HBC_STS_FIXED;
        sts_rd[`HBC_STS_DPE_BIT] = dpe_ff;
        sts_rd[`HBC_STS_SSE_BIT] = sse_ff;
        sts_rd[`HBC_STS_RTAS_BIT] = rtas_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // command enables: next values

    // identification dword has no storage, so writes there fall away
    always_comb begin
        nxt_system_error_enable = system_error_enable_ff;
        nxt_parity_error_enable = parity_error_enable_ff;
        // only byte lane 1 and lane 0 hold the two writable bits
        if (wr_cmdsts && cfg_be[1]) begin
            nxt_system_error_enable = cfg_wdata[`HBC_CMD_SYSTEM_ERROR_ENABLE_BIT];
        end
        if (wr_cmdsts && cfg_be[0]) begin
            nxt_parity_error_enable = cfg_wdata[`HBC_CMD_PARITY_ERROR_ENABLE_BIT];
        end
    end

    // command enables: registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            system_error_enable_ff <= `HBC_CMD_SYSTEM_ERROR_ENABLE_RESET;
            parity_error_enable_ff <= `HBC_CMD_PARITY_ERROR_ENABLE_RESET;
        end else begin
            system_error_enable_ff <= nxt_system_error_enable;
            parity_error_enable_ff <= nxt_parity_error_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags: write one to clear, a set in the same cycle wins

    always_comb begin
        nxt_dpe = dpe_ff;
        nxt_sse = sse_ff;
        nxt_rtas = rtas_ff;
        // clears first so the sets below override them
        if (wr_cmdsts && cfg_be[3]) begin
            if (cfg_wdata[16 + `HBC_STS_DPE_BIT]) begin
                nxt_dpe = 1'h0;
            end
            if (cfg_wdata[16 + `HBC_STS_SSE_BIT]) begin
                nxt_sse = 1'h0;
            end
            if (cfg_wdata[16 + `HBC_STS_RTAS_BIT]) begin
                nxt_rtas = 1'h0;
            end
        end
        if (err_bus.dpe_set) begin
            nxt_dpe = 1'h1;
        end
        if (nxt_serr_act) begin
            nxt_sse = 1'h1;
        end
        if (ev_tabort) begin
            nxt_rtas = 1'h1;
        end
    end

    // status flags: registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dpe_ff <= 1'h0;
            sse_ff <= 1'h0;
            rtas_ff <= 1'h0;
        end else begin
            dpe_ff <= nxt_dpe;
            sse_ff <= nxt_sse;
            rtas_ff <= nxt_rtas;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port answer: one cycle after each request, reads and writes

    always_comb begin
        nxt_ack = cfg_req;
        nxt_rdata = rdata_ff;
        if (cfg_req && !cfg_we) begin
            // unmapped offsets read as zero
            nxt_rdata = 32'h0000_0000;
            if (sel_ident) begin
                nxt_rdata = {PART_CODE, MAKER_CODE};
            end else if (sel_cmdsts) begin
                nxt_rdata = {sts_rd, cmd_rd};
            end
        end
    end

    // register port answer: registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
            ack_ff <= 1'h0;
        end else begin
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error gate and its carrier

    always_comb begin
        err_bus.system_error_enable = system_error_enable_ff;
        err_bus.parity_error_enable = parity_error_enable_ff;
        err_bus.perr_serr_en = perr_serr_en;
        err_bus.ev_tabort = ev_tabort;
        err_bus.ev_apar = ev_apar;
        err_bus.ev_dpar = ev_dpar;
        err_bus.ev_perr_smp = ev_perr_smp;
    end

    hbc_err_gate u_gate (
        .err(err_bus.gate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // serr driver: one cycle low per request

    always_comb begin
        nxt_serr_act = err_bus.serr_req;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serr_act_ff <= 1'h0;
        end else begin
            serr_act_ff <= nxt_serr_act;
        end
    end

    // the enable is gated with the live system_error_enable bit as well, so clearing system_error_enable
    // in the cycle of a pending pulse still keeps the pin released
    always_comb begin
        serr_oe_n = ~(serr_act_ff & system_error_enable_ff);
        serr_n_o = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // perr driver: low, then one cycle high so the shared line is restored
    // before release; a new error during the high cycle starts over

    always_comb begin
        nxt_perr_st = perr_st_ff;
        nxt_perr_cnt = perr_cnt_ff;
        case (perr_st_ff)
            HBC_PERR_IDLE: begin
                if (err_bus.perr_req) begin
                    nxt_perr_st = HBC_PERR_LOW;
                    nxt_perr_cnt = `HBC_PERR_LOW_CYCLES;
                end
            end
            HBC_PERR_LOW: begin
                // further errors while low extend the low phase
                if (err_bus.perr_req) begin
                    nxt_perr_cnt = `HBC_PERR_LOW_CYCLES;
                end else if (perr_cnt_ff <= 2'h1) begin
                    nxt_perr_st = HBC_PERR_HIGH;
                    nxt_perr_cnt = 2'h0;
                end else begin
                    nxt_perr_cnt = perr_cnt_ff - 2'h1;
                end
            end
            HBC_PERR_HIGH: begin
                if (err_bus.perr_req) begin
                    nxt_perr_st = HBC_PERR_LOW;
                    nxt_perr_cnt = `HBC_PERR_LOW_CYCLES;
                end else begin
                    nxt_perr_st = HBC_PERR_IDLE;
                end
            end
            default: begin
                nxt_perr_st = HBC_PERR_IDLE;
                nxt_perr_cnt = 2'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            perr_st_ff <= HBC_PERR_IDLE;
            perr_cnt_ff <= 2'h0;
        end else begin
            perr_st_ff <= nxt_perr_st;
            perr_cnt_ff <= nxt_perr_cnt;
        end
    end

    // pin drive follows the state directly
    always_comb begin
        perr_oe_n = (perr_st_ff == HBC_PERR_IDLE);
        perr_n_o = (perr_st_ff != HBC_PERR_LOW);
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        cfg_rdata = rdata_ff;
        cfg_ack = ack_ff;
        cmd_system_error_enable = system_error_enable_ff;
        cmd_parity_error_enable = parity_error_enable_ff;
    end
endmodule

/* testbench/hbc_cfg_top_properties.sv */
/*
 * checker for the host bridge identification and command registers.
 * assumes it sees only the top module ports, all on ref_clk.
 */
`timescale 1ns/1ns
module hbc_cfg_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic cfg_ack,
    input wire logic perr_serr_en,
    input wire logic ev_tabort,
    input wire logic ev_apar,
    input wire logic ev_dpar,
    input wire logic ev_perr_smp,
    input wire logic serr_oe_n,
    input wire logic perr_n_o,
    input wire logic perr_oe_n,
    input wire logic cmd_system_error_enable,
    input wire logic cmd_parity_error_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // one-cycle memory of a permitted serr cause; serr may only follow one
    logic cause_ff;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cause_ff <= 1'b0;
        end else begin
            cause_ff <= cmd_system_error_enable & (ev_tabort | (cmd_parity_error_enable & (ev_apar | (ev_perr_smp & perr_serr_en))));
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_apar;
        ev_apar && cmd_system_error_enable && cmd_parity_error_enable ##1 cmd_system_error_enable;
    endsequence
    sequence s_dpar_once;
        ev_dpar && cmd_parity_error_enable ##1 !ev_dpar [*2];
    endsequence
    a_ack_pulse: assert property (cfg_req |=> cfg_ack) else $error("no ack after request");
    a_ack_only: assert property (!cfg_req |=> !cfg_ack) else $error("ack without request");
    a_serr_off: assert property (!cmd_system_error_enable |-> serr_oe_n) else $error("serr driven while disabled");
    a_serr_cause: assert property (!serr_oe_n |-> cause_ff) else $error("serr without permitted cause");
    a_tabort_serr: assert property (ev_tabort && cmd_system_error_enable ##1 cmd_system_error_enable |-> !serr_oe_n)
        else $error("target abort did not drive serr");
    a_apar_serr: assert property (s_apar |-> !serr_oe_n) else $error("address parity missed serr");
    a_perr_low: assert property (ev_dpar && cmd_parity_error_enable |=> !perr_oe_n && !perr_n_o)
        else $error("data parity not reported on perr");
    a_perr_tail: assert property (s_dpar_once |-> perr_n_o && !perr_oe_n ##1 perr_oe_n)
        else $error("perr high drive or release wrong");
    a_perr_quiet: assert property (perr_oe_n && !(ev_dpar && cmd_parity_error_enable) |=> perr_oe_n)
        else $error("perr driven without cause");
    a_cmd_hold: assert property (!(cfg_req && cfg_we) |=> $stable(cmd_system_error_enable) && $stable(cmd_parity_error_enable))
        else $error("enables changed without write");
endmodule

bind hbc_cfg_top hbc_cfg_props u_props (.ref_clk(ref_clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_ack(cfg_ack), .perr_serr_en(perr_serr_en), .ev_tabort(ev_tabort), .ev_apar(ev_apar),
    .ev_dpar(ev_dpar), .ev_perr_smp(ev_perr_smp), .serr_oe_n(serr_oe_n), .perr_n_o(perr_n_o),
    .perr_oe_n(perr_oe_n), .cmd_system_error_enable(cmd_system_error_enable), .cmd_parity_error_enable(cmd_parity_error_enable));

/* testbench/hbc_bus_agent.sv */
/*
 * model of the bus logic beside the bridge: turns a request mask into event pulses
 * and resolves the pulled-up serr and perr lines.
 * assumes ev_req is held one cycle by the bench.
 */
`timescale 1ns/1ns
module hbc_bus_agent (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] ev_req,
    output logic [3:0] ev_ff,
    input wire logic serr_oe_n,
    input wire logic serr_n_o,
    input wire logic perr_oe_n,
    input wire logic perr_n_o,
    output logic serr_line,
    output logic perr_line
);
    logic [3:0] nxt_ev;
    // released lines float to the pull-up level, never to a stale value
    assign serr_line = serr_oe_n ? 1'b1 : serr_n_o;
    assign perr_line = perr_oe_n ? 1'b1 : perr_n_o;
    always_comb begin
        nxt_ev = ev_req;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev_ff <= 4'h0;
        end else begin
            ev_ff <= nxt_ev;
        end
    end
endmodule

/* testbench/tb_host_bridge_pci_id_and_command_regs.sv */
/*
 * self-checking bench for the host bridge identification and command registers.
 * assumes one dword access per cfg_req and a one-cycle ack.
 */
`timescale 1ns/1ns
module tb_host_bridge_pci_id_and_command_regs;
    localparam logic [15:0] MAKER = 16'h5A01; // arbitrary value
    localparam logic [15:0] PART = 16'h6B02;  // arbitrary value
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_req = 1'b0, cfg_we = 1'b0, perr_serr_en = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0, ev_req = 4'h0, ev;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
    logic cfg_ack, serr_n_o, serr_oe_n, perr_n_o, perr_oe_n, cmd_system_error_enable, cmd_parity_error_enable, serr_line, perr_line;
    int error_cnt = 0;
    int n_checks = 0;
    always #5 ref_clk = ~ref_clk;
    hbc_cfg_top #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut (.ref_clk(ref_clk), .rst(rst), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .perr_serr_en(perr_serr_en), .ev_tabort(ev[0]), .ev_apar(ev[1]), .ev_dpar(ev[2]),
        .ev_perr_smp(ev[3]), .serr_n_o(serr_n_o), .serr_oe_n(serr_oe_n), .perr_n_o(perr_n_o),
        .perr_oe_n(perr_oe_n), .cmd_system_error_enable(cmd_system_error_enable), .cmd_parity_error_enable(cmd_parity_error_enable));
    hbc_bus_agent agent (.ref_clk(ref_clk), .rst(rst), .ev_req(ev_req), .ev_ff(ev), .serr_oe_n(serr_oe_n),
        .serr_n_o(serr_n_o), .perr_oe_n(perr_oe_n), .perr_n_o(perr_n_o), .serr_line(serr_line),
        .perr_line(perr_line));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one access; request held until the edge that takes it, ack one cycle later
    task automatic cfg_rw(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
        @(posedge ref_clk);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= wd;
        @(posedge ref_clk);
        cfg_req <= 1'b0;
        #1 chk("ack", {31'h0, cfg_ack}, 32'h1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        cfg_rw(1'b0, a, 4'h0, 32'h0);
        chk("rdata", cfg_rdata, exp);
    endtask
    // raise events for one cycle, then look at serr and the full perr sequence
    task automatic event_chk(input logic [3:0] m, input logic es, input logic ep);
        @(posedge ref_clk);
        ev_req <= m;
        @(posedge ref_clk);
        ev_req <= 4'h0;
        @(posedge ref_clk);
        #1 chk("serr_perr", {30'h0, serr_line, perr_line}, {30'h0, ~es, ~ep});
        @(posedge ref_clk);
        #1 chk("serr_perr_tail", {30'h0, serr_line, perr_oe_n}, {30'h0, 1'b1, ~ep});
        @(posedge ref_clk);
        #1 chk("perr_release", {31'h0, perr_oe_n}, 32'h1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need well under 400 cycles
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(8'h00, {PART, MAKER});
        rdc(8'h04, 32'h0200_0006);
        cfg_rw(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF);
        rdc(8'h00, {PART, MAKER});
        cfg_rw(1'b1, 8'h04, 4'h3, 32'h0000_FFFF);
        rdc(8'h04, 32'h0200_0146);
        chk("enables", {30'h0, cmd_system_error_enable, cmd_parity_error_enable}, 32'h3);
        rdc(8'h08, 32'h0);
        $display("test registers done");
        cfg_rw(1'b1, 8'h04, 4'h3, 32'h0);
        @(posedge ref_clk);
        perr_serr_en <= 1'b1;
        event_chk(4'hF, 1'b0, 1'b0);
        rdc(8'h04, 32'h9200_0006);
        cfg_rw(1'b1, 8'h04, 4'h8, 32'hD000_0000);
        rdc(8'h04, 32'h0200_0006);
        $display("test disabled done");
        cfg_rw(1'b1, 8'h04, 4'h3, 32'h0000_0100);
        event_chk(4'h1, 1'b1, 1'b0);
        event_chk(4'h2, 1'b0, 1'b0);
        event_chk(4'h8, 1'b0, 1'b0);
        event_chk(4'h4, 1'b0, 1'b0);
        rdc(8'h04, 32'hD200_0106);
        $display("test serr only done");
        cfg_rw(1'b1, 8'h04, 4'h3, 32'h0000_0140);
        event_chk(4'h2, 1'b1, 1'b0);
        event_chk(4'h4, 1'b0, 1'b1);
        event_chk(4'h8, 1'b1, 1'b0);
        @(posedge ref_clk);
        perr_serr_en <= 1'b0;
        event_chk(4'h8, 1'b0, 1'b0);
        $display("test both enables done");
        cfg_rw(1'b1, 8'h04, 4'h3, 32'h0000_0040);
        event_chk(4'h2, 1'b0, 1'b0);
        event_chk(4'h1, 1'b0, 1'b0);
        $display("test parity only done");
        end_sim();
    end
endmodule
